//--- bench/power_mode_clock_manager_chk.sv
// Port-level checker for the power-mode and clock manager.
// Assumes it is bound into the manager and sees only its ports.
`timescale 1ns/1ps
module power_mode_clock_manager_chk
  import pm_clk_pkg::*;
#(
  parameter int GPIO_N = 31
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Domain and clock controls.
  input wire logic cpuClkEn,
  input wire logic memClkEn,
  input wire logic flashPwr,
  input wire logic sramPwr,
  input wire logic regRetainFull,
  input wire logic slowClkEn,
  input wire logic sramRetain,
  input wire logic periphClkEn,
  input wire logic radioEn,
  input wire logic mainClkEn,
  input wire logic mainClkXtal,
  input wire logic mediumClkEn,
  input wire logic [1:0] slowClkSrc,
  input wire logic slowClkOut,
  input wire logic alwaysOnPwr,
  input wire logic sensorPwr,
  input wire logic regRetainPartial,
  input wire logic cpuResume,
  input wire logic sysReset,
  input wire logic [GPIO_N-1:0] gpioOut,
  input wire logic [GPIO_N-1:0] gpioOe,
  // Bus response.
  input wire logic hresp
);
  logic [1:0] armedReg;

  // The first edges after reset still see reset values through $past, so they are skipped.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armedReg <= 2'h0;
    end else begin
      armedReg <= {armedReg[0], 1'b1};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_active;
    cpuClkEn |-> memClkEn && flashPwr && sramPwr && regRetainFull && periphClkEn && mainClkEn && mediumClkEn;
  endproperty
  a_active: assert property (p_active) else $error("active outputs wrong");
  property p_idle; !cpuClkEn && flashPwr |-> periphClkEn && !memClkEn && mediumClkEn && sramPwr && regRetainFull; endproperty
  a_idle: assert property (p_idle) else $error("idle outputs wrong");
  property p_standby;
    sramRetain |-> regRetainPartial && alwaysOnPwr && !flashPwr && !periphClkEn && !mainClkEn && !radioEn
      && slowClkEn && !sramPwr && !regRetainFull;
  endproperty
  a_standby: assert property (p_standby) else $error("standby outputs wrong");
  property p_off;
    !alwaysOnPwr |-> !sensorPwr && !mediumClkEn && !sramRetain && !cpuClkEn && !mainClkEn
      && !slowClkEn && !sramPwr && !regRetainFull;
  endproperty
  a_off: assert property (p_off) else $error("shutdown outputs wrong");
  property p_latch;
    armedReg[1] && (sramRetain || !alwaysOnPwr) && $past(sramRetain || !alwaysOnPwr) |-> $stable(gpioOut)
      && $stable(gpioOe);
  endproperty
  a_latch: assert property (p_latch) else $error("latched pins moved");
  property p_radio; radioEn |-> mainClkXtal && mainClkEn; endproperty
  a_radio: assert property (p_radio) else $error("radio without crystal");
  property p_slow_out; slowClkOut |-> slowClkSrc != SLOW_SRC_EXT; endproperty
  a_slow_out: assert property (p_slow_out) else $error("slow clock out from pin");
  property p_resume; $rose(cpuClkEn) && $past(sramRetain) |-> cpuResume && !sysReset ##1 !cpuResume; endproperty
  a_resume: assert property (p_resume) else $error("standby exit not a resume");
  property p_wake_reset; armedReg[1] && $rose(cpuClkEn) && $past(!alwaysOnPwr && !sysReset) |-> sysReset[*4]; endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("shutdown wake without reset");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");

  // Main scenarios reached.
  c_resume: cover property (cpuResume);
  c_wake: cover property (armedReg[1] && $rose(cpuClkEn) && $past(!alwaysOnPwr));
  c_radio: cover property (radioEn);
endmodule : power_mode_clock_manager_chk

//--- bench/power_mode_clock_manager_tb_top.sv
// Self-checking testbench for the power-mode and clock manager.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps
module power_mode_clock_manager_tb_top;
  import pm_clk_pkg::*;
  localparam int GPIO_N = 31;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, cpuSleepReq = 1'b0, irqPending = 1'b0, resetPin_n = 1'b1;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd, hrdata;
  logic [2:0] wake = 3'h0; // RTC, sensor, external pin.
  logic [2:0] slowIn = 3'h0; // RC, crystal, external.
  logic [GPIO_N-1:0] gpioPinIn = '0, outReq = '0, oeReq = '0, gpioOut;
  logic cpuClkEn, memClkEn, flashPwr, sramRetain, periphClkEn, radioEn, mainClkEn, mainClkXtal;
  logic mediumClkEn, slowClkOut, alwaysOnPwr, sensorPwr, regRetainPartial, cpuResume, sysReset, hreadyout;
  logic [1:0] slowClkSrc;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  power_mode_clock_manager #(.GPIO_N(GPIO_N)) power_mode_clock_manager_i (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp(), .hrdata, .cpuSleepReq, .irqPending, .rtcEvent(wake[0]), .sensorEvent(wake[1]),
    .resetPin_n, .extWakePin(wake[2]), .slowXtalPin(slowIn[1]), .slowExtPin(slowIn[2]), .gpioPinIn,
    .gpioOutReq(outReq), .gpioOeReq(oeReq), .slowRcIn(slowIn[0]), .cpuClkEn, .memClkEn, .flashPwr,
    .sramPwr(), .sramRetain, .periphClkEn, .radioEn, .mainClkEn, .mainClkXtal, .mediumClkEn,
    .slowClkEn(), .slowClkSrc, .slowClkOut, .alwaysOnPwr, .sensorPwr, .regRetainFull(),
    .regRetainPartial, .cpuResume, .sysReset, .gpioOut, .gpioOe()
  );

  // A 2.5 ns half period gives the 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;

  // The whole run needs a few hundred cycles, so this ceiling only trips on a hang.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // Compares one value; a mismatch is reported at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One single-word transfer; each phase is held until hready is seen high.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Waits, bounded, for the processor clock to come back.
  task automatic waitCpu();
    repeat (40) if (cpuClkEn !== 1'b1) @(negedge ref_clk);
  endtask : waitCpu

  // The target is written first and only then is the sleep request made.
  task automatic sleep(input logic [31:0] ctrl);
    bus(CTRL_OFFSET, 1'b1, ctrl);
    @(posedge ref_clk);
    cpuSleepReq <= 1'b1;
    @(posedge ref_clk);
    cpuSleepReq <= 1'b0;
    cyc(2);
  endtask : sleep

  task automatic sPor();
    bus(CAUSE_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h1);
    bus(8'h10, 1'b1, 32'hffffffff);
    bus(8'h10, 1'b0, 32'h0);
    check(rd, 32'h0);
    bus(STATUS_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h0);
    check(32'({cpuClkEn, memClkEn, flashPwr, periphClkEn, mainClkEn, alwaysOnPwr}), 32'h3f);
  endtask : sPor

  task automatic sIdle();
    sleep({30'h0, TARGET_IDLE});
    check(32'({cpuClkEn, memClkEn, periphClkEn, flashPwr, mediumClkEn}), 32'h7);
    bus(STATUS_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h1);
    @(posedge ref_clk);
    irqPending <= 1'b1;
    waitCpu();
    check(32'(cpuClkEn), 32'h1);
    @(posedge ref_clk);
    irqPending <= 1'b0;
  endtask : sIdle

  // Each wake source in turn; the medium clock is left off in standby once.
  task automatic sStandby();
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      outReq <= 31'h2a5c0f31 ^ 31'(i);
      oeReq <= 31'h7fff0000;
      sleep({24'h0, i != 1, 7'h1});
      @(posedge ref_clk);
      outReq <= ~outReq;
      cyc(3);
      check(32'({sramRetain, mediumClkEn, mainClkEn, flashPwr}), 32'({1'b1, i != 1, 2'h0}));
      check(32'(gpioOut), 32'(31'h2a5c0f31 ^ 31'(i)));
      @(posedge ref_clk);
      wake <= 3'h1 << i;
      waitCpu();
      check(32'({cpuClkEn, cpuResume, sysReset}), 32'h6);
      @(posedge ref_clk);
      wake <= 3'h0;
      bus(CTRL_OFFSET, 1'b0, 32'h0);
      check(rd, {24'h0, i != 1, 7'h1});
    end
  endtask : sStandby

  task automatic sShutdown();
    bus(WAKE_MASK_OFFSET, 1'b1, 32'h1);
    bus(WAKE_MASK_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h1);
    @(posedge ref_clk);
    outReq <= 31'h1357;
    sleep({30'h0, TARGET_SHUTDOWN});
    @(posedge ref_clk);
    outReq <= 31'h0;
    cyc(3);
    check(32'({alwaysOnPwr, sensorPwr, mediumClkEn, sramRetain}), 32'h0);
    check(32'(gpioOut), 32'h1357);
    @(posedge ref_clk);
    gpioPinIn <= 31'h2;
    cyc(10);
    check(32'(alwaysOnPwr), 32'h0);
    @(posedge ref_clk);
    gpioPinIn <= 31'h3;
    waitCpu();
    check(32'({cpuClkEn, sysReset}), 32'h3);
    cyc(25);
    check(32'(sysReset), 32'h0);
    bus(CAUSE_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h4);
    bus(CTRL_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h0);
  endtask : sShutdown

  // The reset pin is pulled from standby, the awkward case.
  task automatic sResetPin();
    sleep({30'h0, TARGET_STANDBY});
    @(posedge ref_clk);
    resetPin_n <= 1'b0;
    cyc(6);
    check(32'({sysReset, cpuClkEn, sramRetain}), 32'h4);
    bus(STATUS_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h4);
    @(posedge ref_clk);
    resetPin_n <= 1'b1;
    waitCpu();
    check(32'(cpuClkEn), 32'h1);
    cyc(25);
    bus(CAUSE_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h2);
    bus(CTRL_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h0);
  endtask : sResetPin

  task automatic sClocks();
    bus(CTRL_OFFSET, 1'b1, 32'h40);
    cyc(3);
    check(32'({radioEn, mainClkXtal}), 32'h0);
    bus(CTRL_OFFSET, 1'b1, 32'h44);
    cyc(3);
    check(32'({radioEn, mainClkXtal}), 32'h3);
    bus(STATUS_OFFSET, 1'b0, 32'h0);
    check(rd, 32'h18);
    for (int s = 0; s < 3; s++) begin
      bus(CTRL_OFFSET, 1'b1, 32'(s) << 3);
      bus(CTRL_OFFSET, 1'b1, (32'(s) << 3) | 32'h20);
      for (int v = 1; v >= 0; v--) begin
        @(posedge ref_clk);
        slowIn <= {3{v[0]}};
        cyc(6);
        check(32'({slowClkSrc, slowClkOut}), 32'({s[1:0], v[0] && s != 2}));
      end
    end
  endtask : sClocks

  // Reset for 16 cycles, then the scenarios in order.
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    sPor();
    sIdle();
    sStandby();
    sShutdown();
    sResetPin();
    sClocks();
    conclude();
  end
endmodule : power_mode_clock_manager_tb_top

bind power_mode_clock_manager power_mode_clock_manager_chk #(.GPIO_N(GPIO_N)) power_mode_clock_manager_chk_i (
  .ref_clk, .rst, .cpuClkEn, .memClkEn, .flashPwr, .sramRetain, .periphClkEn, .radioEn, .mainClkEn,
  .mainClkXtal, .mediumClkEn, .slowClkSrc, .slowClkOut, .alwaysOnPwr, .sensorPwr, .regRetainPartial,
  .cpuResume, .sysReset, .gpioOut, .sramPwr, .regRetainFull, .slowClkEn, .gpioOe, .hresp
);

//--- core/pin_sync.sv
// Two-flop synchroniser with change detection for a vector of pins.
// Assumes raw pins are asynchronous to ref_clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Pins and synced results.
  pin_sync_if.sync pins
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] prev_reg;

  // The first stage feeds only the second; change detect looks at later stages.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      level_reg <= '0;
      prev_reg <= '0;
    end else begin
      stage1_reg <= pins.raw;
      level_reg <= stage1_reg;
      prev_reg <= level_reg;
    end
  end

  assign pins.level = level_reg;
  assign pins.changed = level_reg ^ prev_reg;

endmodule : pin_sync

//--- core/pin_sync_if.sv
// Interface carrying raw pins to the synchroniser and synced levels back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pin_sync_if #(
  parameter int W = 8
);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] changed;

  modport sync (input raw, output level, output changed);
  modport user (output raw, input level, input changed);
endinterface : pin_sync_if

//--- core/pm_clk_pkg.sv
// Package for the power-mode and system-clock manager.
// Assumes a single 200 MHz clock domain and a 32-bit AHB-Lite register bus.
package pm_clk_pkg;

  // Power modes of the sequencer.
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_IDLE,
    MODE_STANDBY,
    MODE_SHUTDOWN,
    MODE_HELD
  } power_mode_t;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] WAKE_MASK_OFFSET = 8'h08;
  localparam logic [7:0] CAUSE_OFFSET = 8'h0c;

  // Control register fields.
  localparam int CTRL_TARGET_LSB = 0;
  localparam int CTRL_MAIN_XTAL_BIT = 2;
  localparam int CTRL_SLOW_SRC_LSB = 3;
  localparam int CTRL_SLOW_OUT_BIT = 5;
  localparam int CTRL_RADIO_BIT = 6;
  localparam int CTRL_MEDIUM_SB_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Target-mode codes in the control register.
  localparam logic [1:0] TARGET_IDLE = 2'h0;
  localparam logic [1:0] TARGET_STANDBY = 2'h1;
  localparam logic [1:0] TARGET_SHUTDOWN = 2'h2;

  // Slow clock source codes.
  localparam logic [1:0] SLOW_SRC_RC = 2'h0;
  localparam logic [1:0] SLOW_SRC_XTAL = 2'h1;
  localparam logic [1:0] SLOW_SRC_EXT = 2'h2;

  // Status register fields.
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_MAIN_XTAL_BIT = 3;
  localparam int STATUS_RADIO_BIT = 4;

  // Reset cause bits.
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_PIN_RESET_BIT = 1;
  localparam int CAUSE_WAKE_PIN_BIT = 2;
  localparam logic [2:0] CAUSE_RESET = 3'h1;

  // Positions in the synchronised pin vector.
  localparam int PIN_RESET_N = 0;
  localparam int PIN_EXT_WAKE = 1;
  localparam int PIN_SLOW_XTAL = 2;
  localparam int PIN_SLOW_EXT = 3;
  localparam int PIN_GPIO_LSB = 4;

  // Timing.
  localparam int CLK_MHZ = 200;
  localparam int SYS_RESET_NS = 100;
  localparam int SYS_RESET_CYCLES = (SYS_RESET_NS * CLK_MHZ + 999) / 1000;

endpackage : pm_clk_pkg

//--- core/power_mode_clock_manager.sv
// Power-mode sequencer and system-clock source manager with AHB-Lite registers.
// Assumes on-chip events arrive on ref_clk; pins are synchronised here.
//
// Functional notes
// R1: Active mode runs the CPU, powers flash and SRAM, allows peripherals and radio.
// R2: Idle gates CPU and memory clocks, peripherals stay clocked, any interrupt returns.
// R3: Standby powers only always-on domain; wakes on external, RTC or sensor event. The code also keeps sensorPwr on in standby.
// R4: Standby exit resumes the CPU without reset and keeps peripheral configuration.
// R5: All GPIO pins hold their latched value during standby.
// R6: Shutdown powers off everything; only latched I/O and flash survive.
// R7: A level change on a shutdown wake pin wakes the device as a reset.
// R8: Reset cause register tells wake-pin reset, reset pin and power-on apart.
// R9: Register retention full in active/idle, partial in standby, none below; SRAM likewise.
// R10: Medium clock on in active/idle, optional in standby; main clock off standby and below.
// R11: RTC wakes active/idle/standby; pin edge also shutdown; reset pin wakes always.
// R12: Main clock comes from fast RC or crystal; radio only on the crystal.
// R13: Medium clock always comes from the medium RC oscillator.
// R14: Slow clock selectable from slow RC, slow crystal or external pin clock.
// R15: Slow clock may be driven out when sourced from crystal or RC.
// R16: Software picks the target mode before the sleep request; entry follows the request.
`timescale 1ns/1ps
module power_mode_clock_manager
  import pm_clk_pkg::*;
#(
  parameter int GPIO_N = 31
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Processor and event inputs on ref_clk.
  input wire logic cpuSleepReq,
  input wire logic irqPending,
  input wire logic rtcEvent,
  input wire logic sensorEvent,
  // Asynchronous pins.
  input wire logic resetPin_n,
  input wire logic extWakePin,
  input wire logic slowXtalPin,
  input wire logic slowExtPin,
  input wire logic [GPIO_N-1:0] gpioPinIn,
  // GPIO drive requested by the peripherals.
  input wire logic [GPIO_N-1:0] gpioOutReq,
  input wire logic [GPIO_N-1:0] gpioOeReq,
  // Slow RC oscillator level, on ref_clk.
  input wire logic slowRcIn,
  // Domain and clock controls.
  output logic cpuClkEn,
  output logic memClkEn,
  output logic flashPwr,
  output logic sramPwr,
  output logic sramRetain,
  output logic periphClkEn,
  output logic radioEn,
  output logic mainClkEn,
  output logic mainClkXtal,
  output logic mediumClkEn,
  output logic slowClkEn,
  output logic [1:0] slowClkSrc,
  output logic slowClkOut,
  output logic alwaysOnPwr,
  output logic sensorPwr,
  output logic regRetainFull,
  output logic regRetainPartial,
  output logic cpuResume,
  output logic sysReset,
  // Latched GPIO drive.
  output logic [GPIO_N-1:0] gpioOut,
  output logic [GPIO_N-1:0] gpioOe
);

  localparam int SYNC_W = PIN_GPIO_LSB + GPIO_N;

  power_mode_t mode_reg, mode_next;
  logic [7:0] ctrl_reg;
  logic [GPIO_N-1:0] wakeMask_reg;
  logic [2:0] cause_reg;
  logic addrWrite_reg;
  logic [7:0] addrOff_reg;
  logic [7:0] resetCnt_reg;
  logic heldSeen_reg;
  logic shutdownWake;
  logic standbyWake;
  logic addrPhase;

  pin_sync_if #(.W(SYNC_W)) pins ();

  assign pins.raw = {gpioPinIn, slowExtPin, slowXtalPin, extWakePin, resetPin_n};

  pin_sync #(.W(SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pins(pins)
  );

  // Reads are decoded only for the bus read data register; the decode sits in one function.
  function automatic logic [31:0] readMux(input logic [7:0] off);
    case (off)
      CTRL_OFFSET: readMux = {24'h000000, ctrl_reg};
      STATUS_OFFSET: readMux = {27'h0000000, radioEn, mainClkXtal, mode_reg};
      WAKE_MASK_OFFSET: readMux = 32'(wakeMask_reg);
      CAUSE_OFFSET: readMux = {29'h00000000, cause_reg};
      default: readMux = 32'h00000000;
    endcase
  endfunction : readMux

  assign addrPhase = hsel & htrans[1] & hready;

  // Shutdown only listens to masked wake pins; standby takes any external source.
  assign shutdownWake = |(pins.changed[PIN_GPIO_LSB +: GPIO_N] & wakeMask_reg); // [R7] [R11]
  assign standbyWake = rtcEvent | sensorEvent | pins.level[PIN_EXT_WAKE]
                       | (|pins.changed[PIN_GPIO_LSB +: GPIO_N]); // [R3] [R11]

  // Next power mode; the reset pin overrides every other source.
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_ACTIVE: begin
        if (cpuSleepReq) begin // [R16]
          if (ctrl_reg[CTRL_TARGET_LSB +: 2] == TARGET_SHUTDOWN) begin
            mode_next = MODE_SHUTDOWN;
          end else if (ctrl_reg[CTRL_TARGET_LSB +: 2] == TARGET_STANDBY) begin
            mode_next = MODE_STANDBY;
          end else begin
            mode_next = MODE_IDLE;
          end
        end
      end
      MODE_IDLE: begin
        if (irqPending | rtcEvent | standbyWake) begin // [R2] [R11]
          mode_next = MODE_ACTIVE;
        end
      end
      MODE_STANDBY: begin
        if (standbyWake) begin // [R3]
          mode_next = MODE_ACTIVE;
        end
      end
      MODE_SHUTDOWN: begin
        if (shutdownWake) begin // [R7]
          mode_next = MODE_ACTIVE;
        end
      end
      MODE_HELD: begin
        mode_next = MODE_ACTIVE;
      end
    endcase
    if (!pins.level[PIN_RESET_N] && heldSeen_reg) begin // [R11]
      mode_next = MODE_HELD;
    end
  end

  // Mode register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_ACTIVE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // The synced reset pin reads low until the chain fills, so ignore it briefly.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      heldSeen_reg <= 1'b0;
    end else if (pins.level[PIN_RESET_N]) begin
      heldSeen_reg <= 1'b1;
    end
  end

  // Domain power, clock gating and retention follow the next mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpuClkEn <= 1'b0;
      memClkEn <= 1'b0;
      flashPwr <= 1'b0;
      sramPwr <= 1'b0;
      sramRetain <= 1'b0;
      periphClkEn <= 1'b0;
      alwaysOnPwr <= 1'b0;
      sensorPwr <= 1'b0;
      regRetainFull <= 1'b0;
      regRetainPartial <= 1'b0;
    end else begin
      cpuClkEn <= (mode_next == MODE_ACTIVE); // [R1] [R2]
      memClkEn <= (mode_next == MODE_ACTIVE); // [R2]
      flashPwr <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE); // [R1]
      sramPwr <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE); // [R1]
      sramRetain <= (mode_next == MODE_STANDBY); // [R9]
      periphClkEn <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE); // [R2] [R3]
      alwaysOnPwr <= (mode_next != MODE_SHUTDOWN) && (mode_next != MODE_HELD); // [R3] [R6]
      sensorPwr <= (mode_next != MODE_SHUTDOWN) && (mode_next != MODE_HELD); // [R6]
      regRetainFull <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE); // [R9]
      regRetainPartial <= (mode_next == MODE_STANDBY); // [R9]
    end
  end

  // Clock sources; the radio is refused unless the crystal drives the main clock.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mainClkEn <= 1'b0;
      mainClkXtal <= 1'b0;
      mediumClkEn <= 1'b0;
      slowClkEn <= 1'b0;
      slowClkSrc <= SLOW_SRC_RC;
      radioEn <= 1'b0;
    end else begin
      mainClkEn <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE); // [R10]
      mainClkXtal <= ctrl_reg[CTRL_MAIN_XTAL_BIT]; // [R12]
      mediumClkEn <= (mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE)
                     || ((mode_next == MODE_STANDBY) && ctrl_reg[CTRL_MEDIUM_SB_BIT]); // [R10] [R13]
      slowClkEn <= (mode_next != MODE_SHUTDOWN) && (mode_next != MODE_HELD);
      slowClkSrc <= ctrl_reg[CTRL_SLOW_SRC_LSB +: 2]; // [R14]
      radioEn <= ctrl_reg[CTRL_RADIO_BIT] && ctrl_reg[CTRL_MAIN_XTAL_BIT]
                 && ((mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE)); // [R1] [R12]
    end
  end

  // Slow clock out: only the crystal and RC sources may be forwarded.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slowClkOut <= 1'b0;
    end else if (ctrl_reg[CTRL_SLOW_OUT_BIT] && (mode_next != MODE_SHUTDOWN) && (mode_next != MODE_HELD)) begin
      // Decoded from the same bits as slowClkSrc, so a source switch never forwards the old source.
      if (ctrl_reg[CTRL_SLOW_SRC_LSB +: 2] == SLOW_SRC_XTAL) begin
        slowClkOut <= pins.level[PIN_SLOW_XTAL]; // [R15]
      end else if (ctrl_reg[CTRL_SLOW_SRC_LSB +: 2] == SLOW_SRC_RC) begin
        slowClkOut <= slowRcIn; // [R15]
      end else begin
        slowClkOut <= 1'b0;
      end
    end else begin
      slowClkOut <= 1'b0;
    end
  end

  // The external slow clock is selectable but never forwarded; its synced level is not read anywhere.
  // GPIO drive tracks the peripherals while awake and freezes otherwise.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gpioOut <= '0;
      gpioOe <= '0;
    end else if ((mode_next == MODE_ACTIVE) || (mode_next == MODE_IDLE)) begin
      gpioOut <= gpioOutReq;
      gpioOe <= gpioOeReq;
    end
  end // Held unchanged in standby and shutdown. [R5] [R6]

  // Standby exit is a warm resume; shutdown wake and reset pin raise a system reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpuResume <= 1'b0;
    end else begin
      cpuResume <= (mode_reg == MODE_STANDBY) && (mode_next == MODE_ACTIVE); // [R4]
    end
  end

  // Reset pulse width is stretched so slow logic in the core sees it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resetCnt_reg <= '0;
      sysReset <= 1'b0;
    end else if (((mode_reg == MODE_SHUTDOWN) && (mode_next == MODE_ACTIVE))
                 || (mode_next == MODE_HELD)) begin
      resetCnt_reg <= 8'(SYS_RESET_CYCLES); // [R7]
      sysReset <= 1'b1;
    end else if (resetCnt_reg != 8'h00) begin
      resetCnt_reg <= resetCnt_reg - 8'h01;
      sysReset <= (resetCnt_reg != 8'h01);
    end else begin
      sysReset <= 1'b0;
    end
  end

  // Reset cause: power-on at reset, then replaced by each later reset event.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_reg <= CAUSE_RESET;
    end else if ((mode_reg == MODE_SHUTDOWN) && (mode_next == MODE_ACTIVE)) begin
      cause_reg <= 3'(1 << CAUSE_WAKE_PIN_BIT); // [R8]
    end else if ((mode_reg == MODE_HELD) && (mode_next == MODE_ACTIVE)) begin
      cause_reg <= 3'(1 << CAUSE_PIN_RESET_BIT); // [R8]
    end
  end

  // Bus address phase capture; writes land in the following data phase.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addrWrite_reg <= 1'b0;
      addrOff_reg <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      addrWrite_reg <= addrPhase && hwrite;
      addrOff_reg <= {haddr[7:2], 2'b00};
      hrdata <= (addrPhase && !hwrite) ? readMux({haddr[7:2], 2'b00}) : 32'h00000000;
    end
  end

  // Writable registers; only word writes are meaningful, other sizes still store.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      wakeMask_reg <= '0;
    end else if ((mode_next == MODE_HELD) || ((mode_reg == MODE_SHUTDOWN) && (mode_next == MODE_ACTIVE))) begin
      // Neither shutdown nor reset hold keeps register state, so software starts from defaults.
      ctrl_reg <= CTRL_RESET; // [R9]
      wakeMask_reg <= '0; // [R9]
    end else if (addrWrite_reg) begin
      if (addrOff_reg == CTRL_OFFSET) begin
        ctrl_reg <= hwdata[7:0]; // [R12] [R14] [R16]
      end
      if (addrOff_reg == WAKE_MASK_OFFSET) begin
        wakeMask_reg <= hwdata[GPIO_N-1:0]; // [R7]
      end
    end
  end

endmodule : power_mode_clock_manager
